// ---- shared/rtc_alarm_pkg.sv ----
// Constants for the clock and alarm control block
package rtc_alarm_pkg;
   // ----------------------------------------
   // Register byte addresses and alias ops
   // ----------------------------------------
   localparam logic [11:0] CLOCK_CONTROL = 12'h200;
   localparam logic [11:0] ALARM_CONTROL = 12'h210;
   localparam logic [11:0] CLOCK_TIME = 12'h220;
   localparam logic [11:0] CLOCK_DATE = 12'h230;
   localparam logic [11:0] ALARM_TIME = 12'h240;
   localparam logic [11:0] ALARM_DATE = 12'h250;
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_CLR = 2'h1;
   localparam logic [1:0] OP_SET = 2'h2;
   localparam logic [1:0] OP_INV = 2'h3;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ON_BIT = 15;
   localparam int HALF_BIT = 1;
   localparam int EN_BIT = 15;
   localparam int CHIME_BIT = 14;
   localparam int PIV_BIT = 13;
   localparam int SYNC_BIT = 12;
   localparam int MASK_LSB = 8;
   localparam int HR_LSB = 24;
   localparam int MIN_LSB = 16;
   localparam int SEC_LSB = 8;
   localparam int YR_LSB = 24;
   localparam int MON_LSB = 16;
   localparam int DAY_LSB = 8;
   // Implemented bits of each time and date register; write masks for the two control registers
   localparam logic [31:0] CCON_WMASK = 32'h0000_8000;
   localparam logic [31:0] ALRM_WMASK = 32'h0000_cfff;
   localparam logic [31:0] TIME_MASK = 32'h3f7f_7f00;
   localparam logic [31:0] DATE_MASK = 32'hff1f_3f07;
   localparam logic [31:0] ADATE_MASK = 32'h001f_ff07;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int HALF_SEC_MS = 500;
   localparam int HAZARD_CLOCKS = 32;
   localparam logic [31:0] POR_VALUE = 32'h0000_0000;
   // ----------------------------------------
   // Interval codes
   // ----------------------------------------
   typedef enum logic [3:0] {
      IV_HALF = 4'h0, IV_SEC = 4'h1, IV_10SEC = 4'h2, IV_MIN = 4'h3,
      IV_10MIN = 4'h4, IV_HOUR = 4'h5, IV_DAY = 4'h6, IV_WEEK = 4'h7,
      IV_MONTH = 4'h8, IV_YEAR = 4'h9
   } interval_t;
endpackage

// ---- design/rtc_alarm_control.sv ----
// Clock, calendar and alarm control with an APB register slave
module rtc_alarm_control #(
   parameter int unsigned HALF_SEC_CYCLES =
      rtc_alarm_pkg::CLK_HZ / 1000 * rtc_alarm_pkg::HALF_SEC_MS
) (
   // Clock and power-on reset
   input wire logic i_clk,
   input wire logic i_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Alarm pulse
   output logic o_alarm_pulse
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] alias_op(input logic [31:0] old,
         input logic [31:0] wd, input logic [1:0] op);
      unique case (op)
         rtc_alarm_pkg::OP_CLR: alias_op = old & ~wd;
         rtc_alarm_pkg::OP_SET: alias_op = old | wd;
         rtc_alarm_pkg::OP_INV: alias_op = old ^ wd;
         default: alias_op = wd;
      endcase
   endfunction

   // Returns {carry, next} for a BCD field rolling from last to first
   function automatic logic [8:0] bcd_step(input logic [7:0] v,
         input logic [7:0] first, input logic [7:0] last);
      if (v >= last) begin
         bcd_step = {1'b1, first};
      end else if (v[3:0] == 4'h9) begin
         bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_step = {1'b0, v + 8'h01};
      end
   endfunction

   function automatic logic [7:0] month_last(input logic [7:0] mon,
         input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      unique case (mon)
         8'h02: month_last = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
         default: month_last = 8'h31;
      endcase
   endfunction

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic [31:0] prdata_q, rd_d;
   logic pready_q, pslverr_q, hit;
   logic [11:0] base;
   logic [1:0] op;
   logic wr;
   assign base = {i_paddr[11:4], 4'h0};
   assign op = i_paddr[3:2];
   assign hit = base >= rtc_alarm_pkg::CLOCK_CONTROL
             && base <= rtc_alarm_pkg::ALARM_DATE && i_paddr[1:0] == 2'h0;
   assign wr = i_psel && i_penable && pready_q && i_pwrite && hit;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic on_q, half_q, en_q, chime_q, pulse_q;
   logic [3:0] mask_q;
   logic [7:0] rpt_q;
   logic [31:0] time_q, date_q, atime_q, adate_q;
   logic [23:0] presc_q;
   logic half_tick, sec_tick, hazard, event_w, chk_half_q, chk_sec_q, match;
   logic [31:0] alrm_rd, ccon_rd, alrm_new, ccon_new;

   assign ccon_rd = ({31'h0, on_q} << rtc_alarm_pkg::ON_BIT)
                  | ({31'h0, half_q} << rtc_alarm_pkg::HALF_BIT);
   assign alrm_rd = {16'h0, en_q, chime_q, pulse_q, hazard, mask_q, rpt_q};
   assign alrm_new = alias_op(alrm_rd, i_pwdata, op);
   assign ccon_new = alias_op(ccon_rd, i_pwdata, op);

   // Prescaler and half-second tick
   assign half_tick = on_q && presc_q == 24'(HALF_SEC_CYCLES - 1);
   assign sec_tick = half_tick && half_q;
   assign hazard = on_q
      && presc_q >= 24'(HALF_SEC_CYCLES - rtc_alarm_pkg::HAZARD_CLOCKS);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         presc_q <= 24'h0;
         half_q <= 1'b0;
         on_q <= 1'b0;
      end else begin
         if (half_tick) begin
            presc_q <= 24'h0;
            half_q <= ~half_q;
         end else if (on_q) begin
            presc_q <= presc_q + 24'h1;
         end
         if (wr && base == rtc_alarm_pkg::CLOCK_CONTROL) begin
            on_q <= ccon_new[rtc_alarm_pkg::ON_BIT];
         end
      end
   end

   // ----------------------------------------
   // Time and date counting
   // ----------------------------------------
   logic [8:0] s_n, m_n, h_n, d_n, mo_n, y_n, wd_n;
   always_comb begin
      s_n = bcd_step(time_q[15:8], 8'h00, 8'h59);
      m_n = bcd_step(time_q[23:16], 8'h00, 8'h59);
      h_n = bcd_step(time_q[31:24], 8'h00, 8'h23);
      d_n = bcd_step(date_q[15:8], 8'h01,
                     month_last(date_q[23:16], date_q[31:24]));
      mo_n = bcd_step(date_q[23:16], 8'h01, 8'h12);
      y_n = bcd_step(date_q[31:24], 8'h00, 8'h99);
      wd_n = bcd_step(date_q[7:0], 8'h00, 8'h06);
   end

   always_ff @(posedge i_clk) begin
      if (wr && base == rtc_alarm_pkg::CLOCK_TIME) begin
         time_q <= alias_op(time_q, i_pwdata, op) & rtc_alarm_pkg::TIME_MASK;
      end else if (sec_tick) begin
         time_q[15:8] <= s_n[7:0];
         if (s_n[8]) begin
            time_q[23:16] <= m_n[7:0];
         end
         if (s_n[8] && m_n[8]) begin
            time_q[31:24] <= h_n[7:0];
         end
      end
      if (wr && base == rtc_alarm_pkg::CLOCK_DATE) begin
         date_q <= alias_op(date_q, i_pwdata, op) & rtc_alarm_pkg::DATE_MASK;
      end else if (sec_tick && s_n[8] && m_n[8] && h_n[8]) begin
         date_q[7:0] <= wd_n[7:0];
         date_q[15:8] <= d_n[7:0];
         if (d_n[8]) begin
            date_q[23:16] <= mo_n[7:0];
         end
         if (d_n[8] && mo_n[8]) begin
            date_q[31:24] <= y_n[7:0];
         end
      end
      if (wr && base == rtc_alarm_pkg::ALARM_TIME) begin
         atime_q <= alias_op(atime_q, i_pwdata, op) & rtc_alarm_pkg::TIME_MASK;
      end
      if (wr && base == rtc_alarm_pkg::ALARM_DATE) begin
         adate_q <= alias_op(adate_q, i_pwdata, op) & rtc_alarm_pkg::ADATE_MASK;
      end
   end

   // ----------------------------------------
   // Alarm match
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         chk_half_q <= 1'b0;
         chk_sec_q <= 1'b0;
      end else begin
         chk_half_q <= half_tick;
         chk_sec_q <= sec_tick;
      end
   end

   always_comb begin
      unique case (mask_q)
         rtc_alarm_pkg::IV_HALF: match = chk_half_q;
         rtc_alarm_pkg::IV_SEC: match = chk_sec_q;
         rtc_alarm_pkg::IV_10SEC: match = chk_sec_q
            && time_q[11:8] == atime_q[11:8];
         rtc_alarm_pkg::IV_MIN: match = chk_sec_q
            && time_q[15:8] == atime_q[15:8];
         rtc_alarm_pkg::IV_10MIN: match = chk_sec_q
            && time_q[19:8] == atime_q[19:8];
         rtc_alarm_pkg::IV_HOUR: match = chk_sec_q
            && time_q[23:8] == atime_q[23:8];
         rtc_alarm_pkg::IV_DAY: match = chk_sec_q && time_q == atime_q;
         rtc_alarm_pkg::IV_WEEK: match = chk_sec_q && time_q == atime_q
            && date_q[2:0] == adate_q[2:0];
         rtc_alarm_pkg::IV_MONTH: match = chk_sec_q && time_q == atime_q
            && date_q[15:8] == adate_q[15:8];
         // February 29 exists only in leap years
         rtc_alarm_pkg::IV_YEAR: match = chk_sec_q && time_q == atime_q
            && date_q[23:8] == adate_q[23:8];
         default: match = 1'b0;
      endcase
   end
   assign event_w = en_q && match;

   // ----------------------------------------
   // Alarm control register
   // ----------------------------------------
   logic wr_alrm;
   assign wr_alrm = wr && base == rtc_alarm_pkg::ALARM_CONTROL;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         {en_q, chime_q, mask_q, rpt_q} <= 14'h0;
      end else if (wr_alrm) begin
         // Software write wins over a same-cycle alarm in these fields; pulse_q still toggles on that alarm
         en_q <= alrm_new[rtc_alarm_pkg::EN_BIT];
         chime_q <= alrm_new[rtc_alarm_pkg::CHIME_BIT];
         mask_q <= alrm_new[rtc_alarm_pkg::MASK_LSB +: 4];
         rpt_q <= alrm_new[7:0];
      end else if (event_w) begin
         if (rpt_q == 8'h00 && !chime_q) begin
            en_q <= 1'b0;
         end
         if (rpt_q != 8'h00 || chime_q) begin
            rpt_q <= rpt_q - 8'h01;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pulse_q <= 1'b0;
      end else if (wr_alrm && !en_q) begin
         pulse_q <= alrm_new[rtc_alarm_pkg::PIV_BIT];
      end else if (event_w) begin
         pulse_q <= ~pulse_q;
      end
   end
   assign o_alarm_pulse = pulse_q;

   // ----------------------------------------
   // APB read and answer
   // ----------------------------------------
   always_comb begin
      rd_d = 32'h0;
      unique case (base)
         rtc_alarm_pkg::CLOCK_CONTROL: rd_d = ccon_rd;
         rtc_alarm_pkg::ALARM_CONTROL: rd_d = alrm_rd;
         rtc_alarm_pkg::CLOCK_TIME: rd_d = time_q;
         rtc_alarm_pkg::CLOCK_DATE: rd_d = date_q;
         rtc_alarm_pkg::ALARM_TIME: rd_d = atime_q;
         rtc_alarm_pkg::ALARM_DATE: rd_d = adate_q;
         default: rd_d = 32'h0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prdata_q <= rtc_alarm_pkg::POR_VALUE;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= i_psel && !i_penable;
         pslverr_q <= i_psel && !i_penable && !hit;
         prdata_q <= (i_psel && !i_penable && hit && !i_pwrite) ? rd_d : 32'h0;
      end
   end
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   a_en_cleared: assert property (
      event_w && !wr_alrm && rpt_q == 8'h00 && !chime_q |=> !en_q)
      else $error("enable not cleared after last alarm");
   a_rpt_wrap: assert property (
      event_w && !wr_alrm && rpt_q == 8'h00 && chime_q |=> rpt_q == 8'hff)
      else $error("repeat count did not wrap");
   a_rpt_stop: assert property (
      !wr_alrm && !chime_q && rpt_q == 8'h00 |=> rpt_q == 8'h00)
      else $error("repeat count moved below zero");
   a_rpt_dec: assert property (
      event_w && !wr_alrm && rpt_q != 8'h00 |=> rpt_q == $past(rpt_q) - 8'h01)
      else $error("repeat count not decremented");
   a_pulse_toggle: assert property (
      event_w && !wr_alrm |=> pulse_q != $past(pulse_q))
      else $error("pulse did not toggle");
   a_piv_locked: assert property (
      en_q && !event_w |=> $stable(pulse_q))
      else $error("pulse changed while enabled without alarm");
   a_piv_load: assert property (
      wr_alrm && !en_q |=> pulse_q == $past(i_pwdata[13]) || $past(op) != 2'h0)
      else $error("initial value not loaded");
   a_hazard_edge: assert property (
      half_tick |-> hazard ##1 (!hazard || HALF_SEC_CYCLES <= 32))
      else $error("hazard flag wrong around rollover");
   a_tick_only: assert property (
      event_w |-> chk_half_q)
      else $error("alarm outside a tick");
   a_apb_ready: assert property (
      i_psel && !i_penable |=> o_pready ##1 !o_pready)
      else $error("ready not one cycle");

   c_alarm: cover property (event_w);
   c_wrap: cover property (event_w && chime_q && rpt_q == 8'h00);
   c_last: cover property (event_w && !chime_q && rpt_q == 8'h00);
endmodule

// ---- testbench/test_rtc_alarm_control.sv ----
// Self-checking bench for the clock and alarm control block
module test_rtc_alarm_control;
   timeunit 1ns;
   timeprecision 1ps;
   // Half second shortened so alarms come every 100 cycles
   localparam int unsigned HALF = 100;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0;
   logic [31:0] o_prdata;
   logic o_pready;
   logic o_pslverr;
   logic o_alarm_pulse;
   logic [31:0] rdat;
   logic perr;
   logic pulse_prev = 1'b0;
   int n_mismatch = 0;
   int n_tests = 0;
   int n_tog = 0;
   int n_cyc = 0;

   always #20 i_clk = ~i_clk;

   rtc_alarm_control #(.HALF_SEC_CYCLES(HALF)) rtc_alarm_control_i (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .o_alarm_pulse(o_alarm_pulse)
   );

   // ----------------------------------------
   // Pulse toggle counter and hang guard
   // ----------------------------------------
   // Falling edge: the pulse has settled and no task races the count
   always @(negedge i_clk) begin
      if (!i_rst && pulse_prev !== o_alarm_pulse) n_tog++;
      pulse_prev = o_alarm_pulse;
      n_cyc++;
      if (n_cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("Comparisons: %0d, mismatches: %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] upd(logic [31:0] cur, logic [31:0] wd, logic [1:0] op);
      case (op)
         2'h0: return wd;
         2'h1: return cur & ~wd;
         2'h2: return cur | wd;
         default: return cur ^ wd;
      endcase
   endfunction

   // ----------------------------------------
   // APB master: entered just after a rising edge
   // ----------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (n >= 20) n_mismatch++;
      rdat = o_prdata;
      perr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd);
      check(32'(perr), 32'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] msk, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(32'(perr), 32'h0);
      check(rdat & msk, exp);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] cur;
      logic [31:0] wd;
      logic [1:0] op;
      logic [11:0] regs [4];
      logic [31:0] msks [4];
      logic e;
      int base;
      void'($urandom(32'ha064));
      regs = '{rtc_alarm_pkg::CLOCK_TIME, rtc_alarm_pkg::CLOCK_DATE,
               rtc_alarm_pkg::ALARM_TIME, rtc_alarm_pkg::ALARM_DATE};
      msks = '{rtc_alarm_pkg::TIME_MASK, rtc_alarm_pkg::DATE_MASK,
               rtc_alarm_pkg::TIME_MASK, rtc_alarm_pkg::ADATE_MASK};
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      rd(rtc_alarm_pkg::ALARM_CONTROL, 32'hffff_ffff, 32'h0);
      rd(rtc_alarm_pkg::CLOCK_CONTROL, 32'hffff_ffff, 32'h0);
      apb(1'b0, 12'h260, 32'h0);
      check(32'(perr), 32'h1);
      check(rdat, 32'h0);
      apb(1'b1, 12'h212, 32'h0000_ffff);
      check(32'(perr), 32'h1);
      rd(rtc_alarm_pkg::ALARM_CONTROL, 32'hffff_ffff, 32'h0);
      // Random alias traffic with the alarm disabled and the clock off
      cur = 32'h0;
      for (int i = 0; i < 12; i++) begin
         op = 2'($urandom_range(3));
         wd = $urandom & ~32'h0000_9000;
         apb(1'b1, rtc_alarm_pkg::ALARM_CONTROL + {8'h0, op, 2'b00}, wd);
         cur = upd(cur, wd, op) & (rtc_alarm_pkg::ALRM_WMASK | 32'h0000_2000);
         check(32'(o_alarm_pulse), 32'(cur[13]));
         rd(rtc_alarm_pkg::ALARM_CONTROL, 32'hffff_ffff, cur);
      end
      for (int i = 0; i < 4; i++) begin
         wr(regs[i], 32'h0);
         wr(regs[i] + 12'h8, 32'hffff_ffff);
         rd(regs[i], 32'hffff_ffff, msks[i]);
         wr(regs[i] + 12'hc, 32'h5555_5555);
         rd(regs[i], 32'hffff_ffff, msks[i] & 32'haaaa_aaaa);
         wr(regs[i] + 12'h4, 32'hffff_ffff);
         rd(regs[i], 32'hffff_ffff, 32'h0);
      end
      // Chime on, repeat 1, every half second
      wr(rtc_alarm_pkg::ALARM_CONTROL, 32'h0);
      wr(rtc_alarm_pkg::ALARM_CONTROL, 32'h0000_c001);
      wr(rtc_alarm_pkg::ALARM_CONTROL + 12'h8, 32'h0000_2000);
      rd(rtc_alarm_pkg::ALARM_CONTROL, 32'hffff_ffff, 32'h0000_c001);
      base = n_tog;
      wr(rtc_alarm_pkg::CLOCK_CONTROL, 32'h0000_8000);
      for (int k = 0; k < 400 && n_tog - base < 3; k++) @(posedge i_clk);
      repeat (10) @(posedge i_clk);
      rd(rtc_alarm_pkg::ALARM_CONTROL, 32'hffff_ffff, 32'h0000_e0fe);
      repeat (62) @(posedge i_clk);
      rd(rtc_alarm_pkg::ALARM_CONTROL, 32'h0000_1000, 32'h0000_1000);
      // Flagged: reread enable and count until two reads agree
      apb(1'b0, rtc_alarm_pkg::ALARM_CONTROL, 32'h0);
      for (int k = 0; k < 4; k++) begin
         cur = rdat;
         apb(1'b0, rtc_alarm_pkg::ALARM_CONTROL, 32'h0);
         if ((rdat & 32'h0000_80ff) == (cur & 32'h0000_80ff)) break;
      end
      check(rdat & 32'h0000_80ff, 32'h0000_80fe);
      // Chime off, repeat 2: three events, then the enable clears
      wr(rtc_alarm_pkg::CLOCK_CONTROL, 32'h0);
      wr(rtc_alarm_pkg::ALARM_CONTROL, 32'h0);
      wr(rtc_alarm_pkg::ALARM_CONTROL, 32'h0000_8002);
      base = n_tog;
      wr(rtc_alarm_pkg::CLOCK_CONTROL, 32'h0000_8000);
      repeat (450) @(posedge i_clk);
      check(32'(n_tog - base), 32'h3);
      check(32'(o_alarm_pulse), 32'h1);
      rd(rtc_alarm_pkg::ALARM_CONTROL, 32'hffff_cfff, 32'h0);
      // Every interval code, with a matching and a missing alarm time
      for (int m = 0; m < 20; m++) begin
         e = (m % 2 == 0) || (m < 4);
         wr(rtc_alarm_pkg::CLOCK_CONTROL, 32'h0);
         wr(rtc_alarm_pkg::ALARM_CONTROL, 32'h0);
         wr(rtc_alarm_pkg::CLOCK_TIME, 32'h1234_5600);
         wr(rtc_alarm_pkg::CLOCK_DATE, 32'h2405_1703);
         wr(rtc_alarm_pkg::ALARM_TIME, (m % 2 == 0) ? 32'h1234_5700 : 32'h1234_5200);
         wr(rtc_alarm_pkg::ALARM_DATE, 32'h0005_1703);
         wr(rtc_alarm_pkg::ALARM_CONTROL, 32'h0000_8000 | (32'(m / 2) << 8));
         base = n_tog;
         wr(rtc_alarm_pkg::CLOCK_CONTROL, 32'h0000_8000);
         repeat (450) @(posedge i_clk);
         check(32'(n_tog - base), 32'(e));
         rd(rtc_alarm_pkg::ALARM_CONTROL, 32'h0000_8000, {16'h0, !e, 15'h0});
      end
      // Yearly alarm on February 29: only the leap year reaches that day
      for (int y = 0; y < 2; y++) begin
         wr(rtc_alarm_pkg::CLOCK_CONTROL, 32'h0);
         wr(rtc_alarm_pkg::ALARM_CONTROL, 32'h0);
         wr(rtc_alarm_pkg::CLOCK_TIME, 32'h2359_5900);
         wr(rtc_alarm_pkg::CLOCK_DATE, (y == 0) ? 32'h2302_2802 : 32'h2402_2802);
         wr(rtc_alarm_pkg::ALARM_TIME, 32'h0);
         wr(rtc_alarm_pkg::ALARM_DATE, 32'h0002_2900);
         wr(rtc_alarm_pkg::ALARM_CONTROL, 32'h0000_8900);
         base = n_tog;
         wr(rtc_alarm_pkg::CLOCK_CONTROL, 32'h0000_8000);
         repeat (450) @(posedge i_clk);
         check(32'(n_tog - base), 32'(y));
      end
      finish_test();
   end
endmodule
